// ==== common/rx_frame_pkg.sv ====
// constants and carrier types for the receive indication framer
// assumes a 32-bit apb master and a radio side on the same clock
package rx_frame_pkg;
    // frame bytes
    localparam logic [7:0] START_BYTE = 8'h7e;
    localparam logic [7:0] FRAME_TYPE = 8'h90;
    localparam logic [7:0] SUM_BASE = 8'hff;
    localparam logic [7:0] FMT_STANDARD = 8'h00;
    // bytes from type code through options byte
    localparam logic [15:0] FIXED_LEN = 16'h000c;
    // byte positions inside the fixed head
    localparam logic [3:0] POS_START = 4'h0;
    localparam logic [3:0] POS_LEN_HI = 4'h1;
    localparam logic [3:0] POS_LEN_LO = 4'h2;
    localparam logic [3:0] POS_TYPE = 4'h3;
    localparam logic [3:0] POS_LONG = 4'h4;
    localparam logic [3:0] POS_SHORT_HI = 4'hc;
    localparam logic [3:0] POS_SHORT_LO = 4'hd;
    localparam logic [3:0] POS_OPTS = 4'he;
    // register byte addresses
    localparam logic [7:0] REG_FORMAT = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_FRAMES = 8'h0c;
    localparam logic [7:0] REG_STATE = 8'h10;
    // status and mask bits
    localparam int EV_SENT = 0;
    localparam int EV_DROP = 1;
    localparam int EV_W = 2;
    // reset values
    localparam logic [7:0] FORMAT_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [15:0] FRAMES_RST = 16'h0000;

    typedef struct packed {
        logic [1:0] delivery;   // 01 p2mp, 10 directed bcast, 11 mesh
        logic app_secure;
        logic secure_session;
        logic reserved;
        logic all_pan_bcast;
        logic bcast;
        logic acked;
    } rx_opts_t;

    typedef struct packed {
        logic [63:0] src_long;
        logic [15:0] src_short;
        rx_opts_t opts;
        logic [15:0] pay_len;
    } rx_hdr_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// ==== logic/rx_packet_frame_builder.sv ====
// serial receive indication framer with apb registers and interrupt
// assumes radio header, payload and host byte sink share sys_clk_in
// Functional notes
// - frame only while output_format_select equals zero (standard format).
// - byte zero of every frame is the start marker.
// - bytes one and two count bytes between length and checksum.
// - byte three is the type code 0x90.
// - bytes four to eleven carry the sender long address.
// - bytes twelve and thirteen carry the sender short address.
// - options bit 0 acknowledged, bit 1 broadcast.
// - options bit 2 all-pan broadcast, bit 3 reserved zero.
// - options bit 4 secure session, bit 5 application encryption.
// - options bits 7:6 give the delivery method.
// - option flags combine; each bit decoded on its own.
// - payload from byte fifteen, passed unchanged.
// - last byte is 0xff minus low byte of sum from byte three.
`timescale 1ns/10ps
module rx_packet_frame_builder (
    input wire logic sys_clk_in,                  // 100 mhz clock
    input wire logic reset_n_in,                  // async reset, low
    input wire rx_frame_pkg::apb_req_t apb_in,    // apb request bundle
    output logic [31:0] prdata_out,               // apb read data
    output logic pready_out,                      // apb ready
    output logic pslverr_out,                     // apb unmapped address
    input wire logic hdr_valid_in,                // packet header valid
    input wire rx_frame_pkg::rx_hdr_t hdr_in,     // packet header
    output logic hdr_ready_out,                   // header taken
    input wire logic pay_valid_in,                // payload byte valid
    input wire logic [7:0] pay_data_in,           // payload byte
    output logic pay_ready_out,                   // payload byte taken
    output logic tx_valid_out,                    // frame byte valid
    output logic [7:0] tx_data_out,               // frame byte
    input wire logic tx_ready_in,                 // host sink ready
    output logic irq_out                          // level interrupt
);
    // drop state swallows a packet in a non-standard format
    typedef enum logic [2:0] {
        ST_IDLE, ST_HEAD, ST_BODY, ST_SUM, ST_DROP
    } state_t;

    // frame progress and the captured header
    state_t state;
    rx_frame_pkg::rx_hdr_t hdr;
    logic [7:0] fmt;
    logic [3:0] idx;
    logic [15:0] remain;
    logic [7:0] sum;
    logic [7:0] out_byte;
    logic out_valid;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] frames;
    // handshake and next byte helpers
    logic adv;
    logic hdr_take;
    logic pay_take;
    logic load;
    logic [7:0] next_byte;
    logic [1:0] events;
    logic [1:0] clr;
    logic apb_wr;
    logic apb_setup;

    // options byte with the reserved bit forced low
    function automatic logic [7:0] opts_byte(
        input rx_frame_pkg::rx_opts_t o
    );
        rx_frame_pkg::rx_opts_t v;
        v = o;
        v.reserved = 1'b0;
        return v;
    endfunction

    // byte of the fixed head at a given position
    function automatic logic [7:0] head_byte(
        input rx_frame_pkg::rx_hdr_t h,
        input logic [3:0] pos
    );
        logic [15:0] len;
        logic [2:0] lb;
        logic [7:0] b;
        len = 16'(rx_frame_pkg::FIXED_LEN + h.pay_len);
        lb = 3'(pos - rx_frame_pkg::POS_LONG);
        b = 8'h00;
        unique case (pos)
            rx_frame_pkg::POS_START: b = rx_frame_pkg::START_BYTE;
            rx_frame_pkg::POS_LEN_HI: b = len[15:8];
            rx_frame_pkg::POS_LEN_LO: b = len[7:0];
            rx_frame_pkg::POS_TYPE: b = rx_frame_pkg::FRAME_TYPE;
            rx_frame_pkg::POS_SHORT_HI: b = h.src_short[15:8];
            rx_frame_pkg::POS_SHORT_LO: b = h.src_short[7:0];
            rx_frame_pkg::POS_OPTS: b = opts_byte(h.opts);
            default: begin
                if (pos >= rx_frame_pkg::POS_LONG) begin
                    b = h.src_long[8 * (7 - int'(lb)) +: 8];
                end
            end
        endcase
        return b;
    endfunction

    // handshakes; a byte moves on whenever the sink slot is free
    assign adv = !out_valid || tx_ready_in;
    assign hdr_ready_out = (state == ST_IDLE);
    assign hdr_take = hdr_valid_in && hdr_ready_out;
    assign pay_ready_out = (state == ST_BODY && adv) || state == ST_DROP;
    assign pay_take = pay_valid_in && pay_ready_out;
    assign load = adv && (state == ST_HEAD || state == ST_SUM ||
                          (state == ST_BODY && pay_valid_in));
    assign tx_valid_out = out_valid;
    assign tx_data_out = out_byte;

    // value of the byte loaded next
    always_comb begin
        next_byte = 8'h00;
        unique case (state)
            ST_HEAD: next_byte = head_byte(hdr, idx);
            ST_BODY: next_byte = pay_data_in;
            ST_SUM: next_byte = 8'(rx_frame_pkg::SUM_BASE - sum);
            ST_IDLE, ST_DROP: next_byte = 8'h00;
        endcase
    end

    // frame sequencer; packets in other formats are drained unseen
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            hdr <= '0;
            idx <= 4'h0;
            remain <= 16'h0000;
            sum <= 8'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (hdr_take) begin
                        hdr <= hdr_in;
                        remain <= hdr_in.pay_len;
                        idx <= rx_frame_pkg::POS_START;
                        sum <= 8'h00;
                        if (fmt == rx_frame_pkg::FMT_STANDARD) begin
                            state <= ST_HEAD;
                        end else if (hdr_in.pay_len != 16'h0000) begin
                            state <= ST_DROP;
                        end
                    end
                end
                ST_HEAD: begin
                    if (adv) begin
                        idx <= 4'(idx + 4'h1);
                        if (idx >= rx_frame_pkg::POS_TYPE) begin
                            sum <= 8'(sum + next_byte);
                        end
                        if (idx == rx_frame_pkg::POS_OPTS) begin
                            state <= (remain == 16'h0000) ? ST_SUM : ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    if (pay_take) begin
                        sum <= 8'(sum + pay_data_in);
                        remain <= 16'(remain - 16'h0001);
                        if (remain == 16'h0001) begin
                            state <= ST_SUM;
                        end
                    end
                end
                ST_SUM: begin
                    if (adv) begin
                        state <= ST_IDLE;
                    end
                end
                // radio side keeps moving while nothing is sent
                ST_DROP: begin
                    if (pay_take) begin
                        remain <= 16'(remain - 16'h0001);
                        if (remain == 16'h0001) begin
                            state <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // one-byte output stage; held until the sink takes it
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_byte <= 8'h00;
            out_valid <= 1'b0;
        end else if (load) begin
            out_byte <= next_byte;
            out_valid <= 1'b1;
        end else if (tx_ready_in) begin
            out_valid <= 1'b0;
        end
    end

    // sticky events; a set in the clearing cycle wins
    // sent is raised at checksum load, not at its acceptance
    assign events[rx_frame_pkg::EV_SENT] = (state == ST_SUM) && adv;
    assign events[rx_frame_pkg::EV_DROP] =
        hdr_take && (fmt != rx_frame_pkg::FMT_STANDARD);
    assign apb_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign apb_setup = apb_in.psel && !apb_in.penable;
    assign clr = (apb_wr && apb_in.paddr == rx_frame_pkg::REG_STATUS) ?
                 apb_in.pwdata[1:0] : 2'h0;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status <= 2'h0;
        end else begin
            status <= (status & ~clr) | events;
        end
    end
    assign irq_out = |(status & mask);

    // count of frames whose checksum byte has been loaded for the host
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            frames <= rx_frame_pkg::FRAMES_RST;
        end else if (events[rx_frame_pkg::EV_SENT]) begin
            frames <= 16'(frames + 16'h0001);
        end
    end

    // writable registers; format change only affects the next header
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fmt <= rx_frame_pkg::FORMAT_RST;
            mask <= rx_frame_pkg::MASK_RST;
        end else if (apb_wr) begin
            if (apb_in.paddr == rx_frame_pkg::REG_FORMAT) begin
                fmt <= apb_in.pwdata[7:0];
            end
            if (apb_in.paddr == rx_frame_pkg::REG_MASK) begin
                mask <= apb_in.pwdata[1:0];
            end
        end
    end

    // read data and error sampled in setup so access has no wait
    assign pready_out = 1'b1;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (apb_setup) begin
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
            unique case (apb_in.paddr)
                rx_frame_pkg::REG_FORMAT: prdata_out[7:0] <= fmt;
                rx_frame_pkg::REG_STATUS: prdata_out[1:0] <= status;
                rx_frame_pkg::REG_MASK: prdata_out[1:0] <= mask;
                rx_frame_pkg::REG_FRAMES: prdata_out[15:0] <= frames;
                rx_frame_pkg::REG_STATE:
                    prdata_out[0] <= (state != ST_IDLE);
                // unmapped reads answer zero and flag an error
                default: pslverr_out <= 1'b1;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    fmt_gate_a: assert property (hdr_take && fmt != 8'h00 &&
        hdr_in.pay_len != 16'h0000 |=> (state != ST_HEAD && !load) [*2])
        else $error("frame started in a non-standard format");
    start_mark_a: assert property (load && state == ST_HEAD &&
        idx == 4'h0 |=> tx_valid_out && tx_data_out == 8'h7e)
        else $error("start marker wrong");
    len_order_a: assert property (load && state == ST_HEAD &&
        idx == 4'h1 |=> tx_data_out == 8'(($past(hdr.pay_len) + 16'd12) >> 8))
        else $error("length high byte wrong");
    type_code_a: assert property (load && state == ST_HEAD &&
        idx == 4'h3 |=> tx_data_out == 8'h90)
        else $error("type code wrong");
    long_addr_a: assert property (load && state == ST_HEAD &&
        idx == 4'h4 |=> tx_data_out == $past(hdr.src_long[63:56]))
        else $error("long address first byte wrong");
    short_addr_a: assert property (load && state == ST_HEAD &&
        idx == 4'hd |=> tx_data_out == $past(hdr.src_short[7:0]))
        else $error("short address low byte wrong");
    opts_byte_a: assert property (load && state == ST_HEAD &&
        idx == 4'he |=> tx_data_out[3] == 1'b0 &&
        tx_data_out[7:4] == $past(hdr.opts[7:4]))
        else $error("options byte wrong");
    body_pass_a: assert property (load && state == ST_BODY |=>
        tx_data_out == $past(pay_data_in))
        else $error("payload byte altered");
    sum_close_a: assert property (load && state == ST_SUM |=>
        8'(tx_data_out + $past(sum)) == 8'hff && state == ST_IDLE)
        else $error("checksum wrong");
    out_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out))
        else $error("frame byte dropped under back-pressure");

    // later head bytes, one cycle after each load
    len_low_a: assert property (load && state == ST_HEAD &&
        idx == 4'h2 |=>
        tx_data_out == 8'($past(hdr.pay_len) + 16'h000c))
        else $error("length low byte wrong");
    long_last_a: assert property (load && state == ST_HEAD &&
        idx == 4'hb |=>
        tx_data_out == $past(hdr.src_long[7:0]))
        else $error("long address last byte wrong");
    short_high_a: assert property (load && state == ST_HEAD &&
        idx == 4'hc |=>
        tx_data_out == $past(hdr.src_short[15:8]))
        else $error("short address high byte wrong");
    opts_low_a: assert property (load && state == ST_HEAD &&
        idx == 4'he |=>
        tx_data_out[2:0] == $past(hdr.opts[2:0]))
        else $error("options low flags wrong");
    // sequencing: where the frame goes after each fixed point
    start_first_a: assert property (hdr_take &&
        fmt == 8'h00 |=> state == ST_HEAD && idx == 4'h0)
        else $error("standard frame did not start at byte zero");
    body_start_a: assert property (load && state == ST_HEAD &&
        idx == 4'he && remain != 16'h0000 |=> state == ST_BODY)
        else $error("payload not started after options byte");
    empty_body_a: assert property (load && state == ST_HEAD &&
        idx == 4'he && remain == 16'h0000 |=> state == ST_SUM)
        else $error("checksum not next for empty payload");
    // drained packets never reach the host and end on count
    drop_quiet_a: assert property (state == ST_DROP |->
        !load && !hdr_ready_out)
        else $error("drained packet reached the host");
    drop_end_a: assert property (state == ST_DROP && pay_take &&
        remain == 16'h0001 |=> state == ST_IDLE)
        else $error("drain did not stop at payload length");
    // bookkeeping: sticky flag, clear and frame counter
    sent_sticky_a: assert property (events[rx_frame_pkg::EV_SENT] |=>
        status[rx_frame_pkg::EV_SENT])
        else $error("frame sent flag not set");
    sent_clear_a: assert property (apb_wr &&
        apb_in.paddr == rx_frame_pkg::REG_STATUS && apb_in.pwdata[0] &&
        !events[rx_frame_pkg::EV_SENT] |=> !status[rx_frame_pkg::EV_SENT])
        else $error("frame sent flag not cleared");
    frame_count_a: assert property (events[rx_frame_pkg::EV_SENT] |=>
        frames == 16'($past(frames) + 16'h0001))
        else $error("frame counter missed a frame");
endmodule

// ==== sim/host_sink.sv ====
// host byte sink model: takes frame bytes and verifies each frame
// assumes bytes offered with valid held until ready at a rising edge
`timescale 1ns/10ps
module host_sink (
    input wire logic sys_clk_in,       // clock
    input wire logic reset_n_in,       // async reset, low
    input wire logic stall_in,         // slow host when high
    input wire logic tx_valid_in,      // frame byte valid
    input wire logic [7:0] tx_data_in, // frame byte
    output logic tx_ready_out,         // byte accepted
    output logic [15:0] good_out       // frames with a good checksum
);
    logic [1:0] slow;
    logic [15:0] pos;
    logic [15:0] len;
    logic [7:0] sum;
    // slow host: ready one cycle in three
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            slow <= 2'h0;
        else
            slow <= (slow == 2'h2) ? 2'h0 : slow + 2'h1;
    end
    assign tx_ready_out = !stall_in || slow == 2'h2;
    // parser hunts for the start byte so a bad frame cannot lock it up
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pos <= 16'h0;
            len <= 16'h0;
            sum <= 8'h0;
            good_out <= 16'h0;
        end else if (tx_valid_in && tx_ready_out) begin
            if (pos == 16'h0) begin
                if (tx_data_in == 8'h7e)
                    pos <= 16'h1;
                sum <= 8'h0;
            end else begin
                pos <= pos + 16'h1;
                if (pos == 16'h1)
                    len[15:8] <= tx_data_in;
                if (pos == 16'h2)
                    len[7:0] <= tx_data_in;
                if (pos >= 16'h3)
                    sum <= sum + tx_data_in;
                if (pos > 16'h2 && pos == len + 16'h3) begin
                    pos <= 16'h0;
                    if (sum + tx_data_in == 8'hff)
                        good_out <= good_out + 16'h1;
                end
            end
        end
    end
endmodule

// ==== sim/rx_packet_frame_builder_tb_top.sv ====
// self-checking bench for the receive framer: frames, format, irq
// assumes the design package and host_sink compiled before it
`timescale 1ns/10ps
module rx_packet_frame_builder_tb_top;
    logic sys_clk_in;
    logic reset_n_in;
    rx_frame_pkg::apb_req_t apb;
    rx_frame_pkg::rx_hdr_t hdr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hdr_valid;
    logic hdr_ready;
    logic pay_valid;
    logic [7:0] pay_data;
    logic pay_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic irq;
    logic stall;
    logic [15:0] good;
    logic [31:0] rd;
    logic er;
    int errors;
    int tests_run;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    // rows: options in, options expected out, payload length, slow host
    typedef struct packed {
        logic [7:0] oi;
        logic [7:0] oo;
        logic [15:0] pl;
        logic st;
    } row_t;
    row_t rows[10] = '{'{8'h01, 8'h01, 16'h6, 1'b0},
        '{8'h02, 8'h02, 16'h0, 1'b0}, '{8'h04, 8'h04, 16'h1, 1'b1},
        '{8'h08, 8'h00, 16'h2, 1'b0}, '{8'h10, 8'h10, 16'h3, 1'b0},
        '{8'h20, 8'h20, 16'h4, 1'b1}, '{8'h40, 8'h40, 16'h5, 1'b0},
        '{8'h80, 8'h80, 16'h1, 1'b0}, '{8'hc0, 8'hc0, 16'h7, 1'b1},
        '{8'hfb, 8'hf3, 16'h3, 1'b0}};

    rx_packet_frame_builder u_dut (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .apb_in(apb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .hdr_valid_in(hdr_valid), .hdr_in(hdr), .hdr_ready_out(hdr_ready),
        .pay_valid_in(pay_valid), .pay_data_in(pay_data),
        .pay_ready_out(pay_ready), .tx_valid_out(tx_valid),
        .tx_data_out(tx_data), .tx_ready_in(tx_ready), .irq_out(irq));
    host_sink u_host (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .stall_in(stall), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
        .tx_ready_out(tx_ready), .good_out(good));

    // clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // collect every byte the host takes
    always @(posedge sys_clk_in) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            got.push_back(tx_data);
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic cond(input int w);
        case (w)
            0: return hdr_ready;
            1: return pay_ready;
            2: return pready;
            default: return got.size() >= exp.size();
        endcase
    endfunction
    // bounded wait, checked on the falling edge where levels are settled
    task automatic waitfor(input int w);
        int n;
        n = 0;
        @(negedge sys_clk_in);
        while (cond(w) !== 1'b1) begin
            n++;
            if (n > 3000) begin
                errors++;
                summarize();
            end
            @(negedge sys_clk_in);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        apb <= '{1'b1, 1'b0, wr, a, d};
        @(posedge sys_clk_in);
        apb.penable <= 1'b1;
        // answer taken only at the edge that samples pready high
        @(posedge sys_clk_in);
        while (pready !== 1'b1) begin
            n++;
            if (n > 3000) begin
                errors++;
                summarize();
            end
            @(posedge sys_clk_in);
        end
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask
    function automatic logic [7:0] pb(input int i, input int k);
        return 8'(i * 37 + k * 5 + 1);
    endfunction
    task automatic send(input int i, input logic [7:0] o,
        input logic [15:0] pl);
        @(posedge sys_clk_in);
        hdr_valid <= 1'b1;
        hdr <= '{64'h0123456789abcdef + i, 16'h5a00 + 16'(i), o, pl};
        waitfor(0);
        @(posedge sys_clk_in);
        hdr_valid <= 1'b0;
        for (int k = 0; k < pl; k++) begin
            pay_valid <= 1'b1;
            pay_data <= pb(i, k);
            waitfor(1);
            @(posedge sys_clk_in);
        end
        pay_valid <= 1'b0;
    endtask
    // expected frame worked out from the field layout
    task automatic build(input int i, input logic [7:0] o,
        input logic [15:0] pl);
        logic [15:0] len;
        logic [63:0] lg;
        logic [7:0] s;
        len = 16'h000c + pl;
        lg = 64'h0123456789abcdef + i;
        exp = '{8'h7e, len[15:8], len[7:0], 8'h90};
        for (int b = 7; b >= 0; b--)
            exp.push_back(lg[b*8 +: 8]);
        exp.push_back(8'h5a);
        exp.push_back(8'(i));
        exp.push_back(o);
        for (int k = 0; k < pl; k++)
            exp.push_back(pb(i, k));
        s = 8'h0;
        for (int b = 3; b < exp.size(); b++)
            s += exp[b];
        exp.push_back(8'hff - s);
    endtask

    initial begin
        errors = 0;
        tests_run = 0;
        apb = '0;
        hdr = '0;
        hdr_valid = 1'b0;
        pay_valid = 1'b0;
        pay_data = 8'h00;
        stall = 1'b0;
        reset_n_in = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        // reset values, then one unmapped address
        for (int a = 0; a < 6; a++) begin
            xfer(1'b0, 8'(a * 4), 32'h0);
            chk(rd, 32'h0);
            chk(er, a == 5);
        end
        xfer(1'b1, 8'h08, 32'h3);
        // standard format: every option code, slow and fast host
        for (int i = 0; i < 10; i++) begin
            stall <= rows[i].st;
            got.delete();
            build(i, rows[i].oo, rows[i].pl);
            send(i, rows[i].oi, rows[i].pl);
            waitfor(3);
            chk(got.size(), exp.size());
            for (int b = 0; b < exp.size() && b < got.size(); b++)
                chk(got[b], exp[b]);
            chk(got[14], rows[i].oo);
            chk(good, 16'(i + 1));
            chk(irq, 1'b1);
            xfer(1'b1, 8'h04, 32'h1);
            @(negedge sys_clk_in);
            chk(irq, 1'b0);
        end
        // other format: packet drained, nothing sent, drop event masked
        xfer(1'b1, 8'h08, 32'h1);
        xfer(1'b1, 8'h00, 32'h1);
        got.delete();
        send(30, 8'h01, 16'h3);
        repeat (20) @(posedge sys_clk_in);
        chk(got.size(), 32'h0);
        xfer(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2);
        chk(irq, 1'b0);
        xfer(1'b1, 8'h08, 32'h3);
        @(negedge sys_clk_in);
        chk(irq, 1'b1);
        xfer(1'b1, 8'h04, 32'h2);
        @(negedge sys_clk_in);
        chk(irq, 1'b0);
        xfer(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'ha);
        // busy flag read while a standard frame is on its way
        xfer(1'b1, 8'h00, 32'h0);
        got.delete();
        build(31, 8'h01, 16'h2);
        fork
            send(31, 8'h01, 16'h2);
            begin
                repeat (3) @(posedge sys_clk_in);
                xfer(1'b0, 8'h10, 32'h0);
            end
        join
        chk(rd, 32'h1);
        waitfor(3);
        chk(got.size(), exp.size());
        for (int b = 0; b < exp.size() && b < got.size(); b++)
            chk(got[b], exp[b]);
        xfer(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
